// ---- hdl/eip_pkg.sv ----
// Notes on behaviour
// R01: low three select bits pick nesting source
// R02: select bit 3 is master enable
// R03: store writes select; instructions change enable
// R04: software clears enable before changing select
// R05: writing 1011 selects ext_irq_b, enables
// R06: reset clears priority select to zero
// R07: filter drops pulses under two samples
// R08: filter passes pulses over two samples
// R09: mode bit 3 picks CPU or osc/64
// R10: mode bits 1:0 pick edge; 11 none
// R11: mode bit 2 bypasses filter, allows wake
// R12: reset clears ext0 mode register
// R13: port read sees filtered ext_irq_a
// R14: rejection width two samples of source
// R15: ext_irq_b rising/falling by own register
// R16: ext_irq_c detects both edges
// R17: request and enable raise vector, wake
// R18: mode write may raise spurious edge
// R19: select codes follow vector table order
package eip_pkg;

  // Register addresses in data memory
  localparam logic [11:0] ADDR_EXT0_MODE = 12'hfb4;
  localparam logic [11:0] ADDR_EXT1_MODE = 12'hfb5;
  localparam logic [11:0] ADDR_PRIO_SEL = 12'hfb2;

  // Field positions
  localparam int MASTER_EN_BIT = 3;
  localparam int M0_BYPASS_BIT = 2;
  localparam int M0_CLK_BIT = 3;
  localparam int M1_FALL_BIT = 0;

  // Edge select codes of ext0_edge_mode
  localparam logic [1:0] EDGE_RISE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h2;
  localparam logic [1:0] EDGE_NONE = 2'h3;

  // Vector numbering; select code n names vector bit n-1 (pend[code - 1])
  localparam int NUM_VEC = 6;
  localparam logic [2:0] CODE_FIRST_VEC = 3'h1;
  localparam logic [2:0] CODE_LAST_VEC = 3'h6;

  // Oscillator divider for the slow sampling clock
  localparam int OSC_DIV = 64;
  localparam logic [5:0] DIV_LAST = 6'(OSC_DIV - 1);

  localparam int NUM_PINS = 3;

  typedef struct packed {
    logic [3:0] prio;
    logic [3:0] m0;
    logic [3:0] m1;
  } eip_regs_s;

  localparam eip_regs_s REGS_RST = '{
    prio: 4'h0, m0: 4'h0, m1: 4'h0};

  typedef struct packed {
    logic wr;
    logic [11:0] addr;
    logic [3:0] wdata;
  } eip_mem_s;

endpackage

// ---- hdl/eip_noise_filter.sv ----
`timescale 1ns/1ps
module eip_noise_filter (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Sampling
  input wire logic sample_en,
  input wire logic din,
  // Filtered level
  output logic dout
);

  typedef struct packed {
    logic smp;
    logic out;
  } eip_flt_s;

  eip_flt_s s;
  eip_flt_s next_s;

  // Output follows only when two successive samples agree
  always_comb begin
    next_s = s;
    if (sample_en) begin
      next_s.smp = din;
      if (din == s.smp) begin // R07
        next_s.out = din; // R08
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign dout = s.out;

  a_flt_hold: assert property (@(posedge clk) // R07
    disable iff (!rst_n)
    !$stable(dout) |-> $past(sample_en))
    else $error("filter output moved without a sample");

  a_flt_pass: assert property (@(posedge clk) // R08
    disable iff (!rst_n)
    sample_en && din == s.smp |=> dout == $past(din))
    else $error("two agreeing samples did not pass");

endmodule

// ---- hdl/eip_ext_irq.sv ----
`timescale 1ns/1ps
module eip_ext_irq (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // CPU data memory port
  input wire eip_pkg::eip_mem_s mem,
  output logic [3:0] mem_rdata,
  // Interrupt control instructions, one-cycle pulses
  input wire logic global_enable_instr,
  input wire logic global_disable_instr,
  // CPU machine-cycle enable and standby state
  input wire logic cpu_cycle_tick,
  input wire logic standby,
  // External interrupt pins
  input wire logic ext_irq_a,
  input wire logic ext_irq_b,
  input wire logic ext_irq_c,
  // Request and enable flags, one per vector
  input wire logic [5:0] vec_req_flag,
  input wire logic [5:0] vec_en_flag,
  // Edge events toward the request flags
  output logic ext_a_edge,
  output logic ext_b_edge,
  output logic ext_c_edge,
  // Filtered ext_irq_a level for port reads
  output logic port_a_level,
  // Priority state
  output logic master_irq_enable,
  output logic [2:0] prio_code,
  // Vectored requests
  output logic [5:0] vec_irq,
  output logic high_prio_irq,
  output logic standby_release
);

  typedef struct packed {
    eip_pkg::eip_regs_s regs;
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [2:0] sync3;
    logic [2:0] lvl;
    logic prev_a;
    logic prev_b;
    logic prev_c;
    logic [5:0] div_cnt;
    logic edge_a;
    logic edge_b;
    logic edge_c;
    logic port_a;
    logic [5:0] vec;
    logic hi;
    logic wake;
    logic [3:0] rdata;
  } eip_top_s;

  eip_top_s s;
  eip_top_s next_s;

  logic osc_tick;
  logic sample_en;
  logic filt_a;
  logic src_a;
  logic src_b;
  logic rise_a;
  logic fall_a;
  logic det_a;
  logic det_b;
  logic [5:0] pend;
  logic next_master_en;
  logic [2:0] code;

  // Slow sampling rate: oscillator taken as clk, divided
  assign osc_tick = (s.div_cnt == eip_pkg::DIV_LAST);

  // No sampling clock in standby, whether bypassed or not
  assign sample_en = !standby &&
    (s.regs.m0[eip_pkg::M0_CLK_BIT] ? osc_tick // R09 R14
                                    : cpu_cycle_tick); // R11

  // Filter sits in the path even in port mode
  eip_noise_filter u_filter (
    .clk(clk),
    .rst_n(rst_n),
    .sample_en(sample_en),
    .din(s.lvl[0]), // R13
    .dout(filt_a)
  );

  // Bypass takes the synchronised pin, so edges still
  // arrive while the sampling clock is stopped
  assign src_a = s.regs.m0[eip_pkg::M0_BYPASS_BIT] ?
    s.lvl[0] : filt_a; // R11
  assign src_b = s.lvl[1];

  assign rise_a = src_a && !s.prev_a;
  assign fall_a = !src_a && s.prev_a;

  always_comb begin
    case (s.regs.m0[1:0])
      eip_pkg::EDGE_RISE: det_a = rise_a; // R10
      eip_pkg::EDGE_FALL: det_a = fall_a;
      eip_pkg::EDGE_BOTH: det_a = rise_a || fall_a;
      eip_pkg::EDGE_NONE: det_a = 1'b0;
      default: det_a = 1'b0;
    endcase
  end

  assign det_b = s.regs.m1[eip_pkg::M1_FALL_BIT] ?
    (!src_b && s.prev_b) : (src_b && !s.prev_b); // R15

  // Disable wins when both instructions arrive together
  always_comb begin
    next_master_en = s.regs.prio[eip_pkg::MASTER_EN_BIT];
    if (mem.wr && mem.addr == eip_pkg::ADDR_PRIO_SEL) begin
      next_master_en = mem.wdata[eip_pkg::MASTER_EN_BIT]; // R05
    end
    if (global_enable_instr) begin
      next_master_en = 1'b1; // R03
    end
    if (global_disable_instr) begin
      next_master_en = 1'b0; // R03
    end
  end

  assign pend = vec_req_flag & vec_en_flag; // R17
  assign code = s.regs.prio[2:0];

  always_comb begin
    next_s = s;

    // Three-stage pin synchroniser
    next_s.sync1 = {ext_irq_c, ext_irq_b, ext_irq_a};
    next_s.sync2 = s.sync1;
    next_s.sync3 = s.sync2;
    for (int i = 0; i < eip_pkg::NUM_PINS; i++) begin
      if (s.sync2[i] == s.sync3[i]) begin
        next_s.lvl[i] = s.sync3[i];
      end
    end

    next_s.div_cnt = (s.div_cnt == eip_pkg::DIV_LAST) ?
      6'h00 : s.div_cnt + 6'h01;

    next_s.prev_a = src_a;
    next_s.prev_b = src_b;
    next_s.prev_c = s.lvl[2];
    next_s.edge_a = det_a;
    next_s.edge_b = det_b;
    next_s.edge_c = s.lvl[2] ^ s.prev_c; // R16
    next_s.port_a = filt_a; // R13

    // A new edge select acts at once, so the old and new
    // decoding may see a false edge; software clears it
    if (mem.wr) begin
      case (mem.addr)
        eip_pkg::ADDR_EXT0_MODE: begin
          next_s.regs.m0 = mem.wdata; // R18
        end
        eip_pkg::ADDR_EXT1_MODE: begin
          next_s.regs.m1 = mem.wdata; // R15 R18
        end
        eip_pkg::ADDR_PRIO_SEL: begin
          next_s.regs.prio[2:0] = mem.wdata[2:0]; // R03 R05
        end
        default: begin
        end
      endcase
    end
    next_s.regs.prio[eip_pkg::MASTER_EN_BIT] = next_master_en; // R02

    // Master enable gates requests; wake does not wait on it
    next_s.vec = next_master_en ? pend : 6'h00; // R02 R17
    next_s.wake = |pend; // R17

    // Codes 1..6 name vectors in table order
    next_s.hi = 1'b0;
    if (code >= eip_pkg::CODE_FIRST_VEC &&
        code <= eip_pkg::CODE_LAST_VEC) begin
      next_s.hi = next_master_en &&
        pend[code - eip_pkg::CODE_FIRST_VEC]; // R01 R19
    end

    case (mem.addr)
      eip_pkg::ADDR_EXT0_MODE: next_s.rdata = s.regs.m0;
      eip_pkg::ADDR_EXT1_MODE: next_s.rdata = s.regs.m1;
      eip_pkg::ADDR_PRIO_SEL: next_s.rdata = s.regs.prio;
      default: next_s.rdata = 4'h0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.regs <= eip_pkg::REGS_RST; // R06 R12
    end else begin
      s <= next_s;
    end
  end

  assign mem_rdata = s.rdata;
  assign ext_a_edge = s.edge_a;
  assign ext_b_edge = s.edge_b;
  assign ext_c_edge = s.edge_c;
  assign port_a_level = s.port_a;
  assign master_irq_enable = s.regs.prio[eip_pkg::MASTER_EN_BIT];
  assign prio_code = s.regs.prio[2:0];
  assign vec_irq = s.vec;
  assign high_prio_irq = s.hi;
  assign standby_release = s.wake;

  a_enable_sets: assert property (@(posedge clk) // R03
    disable iff (!rst_n)
    global_enable_instr && !global_disable_instr
    |=> master_irq_enable)
    else $error("enable instruction did not set enable");

  a_disable_blocks: assert property (@(posedge clk) // R02
    disable iff (!rst_n)
    global_disable_instr |=> !master_irq_enable &&
    vec_irq == 6'h00 && !high_prio_irq)
    else $error("disable instruction left requests open");

  a_store_1011: assert property (@(posedge clk) // R05
    disable iff (!rst_n)
    mem.wr && mem.addr == eip_pkg::ADDR_PRIO_SEL &&
    mem.wdata == 4'hb && !global_enable_instr &&
    !global_disable_instr
    |=> master_irq_enable && prio_code == 3'h3)
    else $error("store of 1011 not taken");

  a_sel_store: assert property (@(posedge clk) // R03
    disable iff (!rst_n)
    mem.wr && mem.addr == eip_pkg::ADDR_PRIO_SEL
    |=> prio_code == $past(mem.wdata[2:0]))
    else $error("store did not write the select code");

  a_enable_hold: assert property (@(posedge clk) // R03
    disable iff (!rst_n)
    !global_enable_instr && !global_disable_instr &&
    !(mem.wr && mem.addr == eip_pkg::ADDR_PRIO_SEL)
    |=> $stable(master_irq_enable))
    else $error("master enable moved with no instruction");

  a_mode0_store: assert property (@(posedge clk) // R09 R10 R11
    disable iff (!rst_n)
    mem.wr && mem.addr == eip_pkg::ADDR_EXT0_MODE
    |=> s.regs.m0 == $past(mem.wdata))
    else $error("ext0 mode store not taken");

  a_mode1_store: assert property (@(posedge clk) // R15
    disable iff (!rst_n)
    mem.wr && mem.addr == eip_pkg::ADDR_EXT1_MODE
    |=> s.regs.m1 == $past(mem.wdata))
    else $error("ext1 mode store not taken");

  a_code_none: assert property (@(posedge clk) // R10
    disable iff (!rst_n)
    s.regs.m0[1:0] == eip_pkg::EDGE_NONE |=> !ext_a_edge)
    else $error("edge reported with edge select 11");

  a_a_rise: assert property (@(posedge clk) // R10
    disable iff (!rst_n)
    s.regs.m0[1:0] == eip_pkg::EDGE_RISE && rise_a |=> ext_a_edge)
    else $error("ext_irq_a rising edge missed");

  a_a_fall: assert property (@(posedge clk) // R10
    disable iff (!rst_n)
    s.regs.m0[1:0] == eip_pkg::EDGE_FALL && fall_a |=> ext_a_edge)
    else $error("ext_irq_a falling edge missed");

  a_a_both: assert property (@(posedge clk) // R10
    disable iff (!rst_n)
    s.regs.m0[1:0] == eip_pkg::EDGE_BOTH && (rise_a || fall_a)
    |=> ext_a_edge)
    else $error("ext_irq_a edge missed in both-edge mode");

  a_bypass_path: assert property (@(posedge clk) // R11
    disable iff (!rst_n)
    s.regs.m0[eip_pkg::M0_BYPASS_BIT] && s.lvl[0] != s.prev_a &&
    s.regs.m0[1:0] == eip_pkg::EDGE_BOTH |=> ext_a_edge)
    else $error("bypassed pin change gave no edge");

  a_c_both: assert property (@(posedge clk) // R16
    disable iff (!rst_n)
    !$stable(s.lvl[2]) |=> ext_c_edge)
    else $error("ext_irq_c change missed");

  a_c_quiet: assert property (@(posedge clk) // R16
    disable iff (!rst_n)
    $stable(s.lvl[2]) |=> !ext_c_edge)
    else $error("ext_irq_c edge without a change");

  a_b_edge: assert property (@(posedge clk) // R15
    disable iff (!rst_n)
    s.regs.m1[eip_pkg::M1_FALL_BIT] && s.prev_b && !src_b
    |=> ext_b_edge)
    else $error("ext_irq_b falling edge missed");

  a_b_rise: assert property (@(posedge clk) // R15
    disable iff (!rst_n)
    !s.regs.m1[eip_pkg::M1_FALL_BIT] && !s.prev_b && src_b
    |=> ext_b_edge)
    else $error("ext_irq_b rising edge missed");

  a_port_filt: assert property (@(posedge clk) // R13
    disable iff (!rst_n)
    ##1 port_a_level == $past(filt_a))
    else $error("port level not the filtered level");

  a_wake_vec: assert property (@(posedge clk) // R17
    disable iff (!rst_n)
    pend != 6'h00 |=> standby_release)
    else $error("pending request did not release standby");

  a_wake_idle: assert property (@(posedge clk) // R17
    disable iff (!rst_n)
    pend == 6'h00 |=> !standby_release)
    else $error("standby released with nothing pending");

  a_vec_gate: assert property (@(posedge clk) // R02 R17
    disable iff (!rst_n)
    ##1 vec_irq == (master_irq_enable ? $past(pend) : 6'h00))
    else $error("vector requests not gated by master enable");

  a_hi_prio: assert property (@(posedge clk) // R01 R19
    disable iff (!rst_n)
    high_prio_irq |-> master_irq_enable &&
    $past(prio_code) >= eip_pkg::CODE_FIRST_VEC &&
    $past(prio_code) <= eip_pkg::CODE_LAST_VEC)
    else $error("high priority request with no valid code");

  a_hi_grant: assert property (@(posedge clk) // R01
    disable iff (!rst_n)
    next_master_en && code == eip_pkg::CODE_LAST_VEC &&
    pend[eip_pkg::NUM_VEC - 1] |=> high_prio_irq)
    else $error("selected source pending without high priority");

  a_hi_none: assert property (@(posedge clk) // R19
    disable iff (!rst_n)
    code < eip_pkg::CODE_FIRST_VEC || code > eip_pkg::CODE_LAST_VEC
    |=> !high_prio_irq)
    else $error("high priority request with an unused code");

  a_stby_freeze: assert property (@(posedge clk) // R11
    disable iff (!rst_n)
    standby |=> $stable(filt_a))
    else $error("filter sampled during standby");

  a_div_wrap: assert property (@(posedge clk) // R14
    disable iff (!rst_n)
    s.div_cnt == eip_pkg::DIV_LAST |=> s.div_cnt == 6'h00)
    else $error("slow sampling divider did not wrap");

endmodule

// ---- tb/eip_cpu_model.sv ----
`timescale 1ns/1ps
module eip_cpu_model #(
  parameter int TICK_DIV = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Instruction cycle pulse
  output logic cpu_cycle_tick
);
  logic [7:0] cnt;

  // Short cycle keeps filtered runs brief; the filter samples on the tick only while mode bit 3 is clear and not in standby
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 8'h00;
      cpu_cycle_tick <= 1'b0;
    end else begin
      cnt <= (cnt == 8'(TICK_DIV - 1)) ? 8'h00 : cnt + 8'h01;
      cpu_cycle_tick <= (cnt == 8'(TICK_DIV - 1));
    end
  end
endmodule

// ---- tb/eip_ext_irq_tb_top.sv ----
`timescale 1ns/1ps
module eip_ext_irq_tb_top;
  logic clk, rst_n, en_instr, dis_instr, standby, tick, a_e, b_e, c_e;
  logic port_a, men, hp, sbr;
  logic [2:0] pin, pc;
  logic [3:0] rdata;
  logic [5:0] req, en, virq;
  logic [7:0] ex [4];
  eip_pkg::eip_mem_s mem;
  int fails, comparisons, cyc, na, nb, nc, mid;

  eip_cpu_model cpu (.clk(clk), .rst_n(rst_n), .cpu_cycle_tick(tick));

  eip_ext_irq dut (.clk(clk), .rst_n(rst_n), .mem(mem), .mem_rdata(rdata),
    .global_enable_instr(en_instr), .global_disable_instr(dis_instr),
    .cpu_cycle_tick(tick), .standby(standby), .ext_irq_a(pin[0]),
    .ext_irq_b(pin[1]), .ext_irq_c(pin[2]), .vec_req_flag(req),
    .vec_en_flag(en), .ext_a_edge(a_e), .ext_b_edge(b_e), .ext_c_edge(c_e),
    .port_a_level(port_a), .master_irq_enable(men), .prio_code(pc),
    .vec_irq(virq), .high_prio_irq(hp), .standby_release(sbr));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Edge pulses are counted on the falling edge, away from the launching edge, to avoid a race
  always @(negedge clk) begin
    cyc++;
    na += int'(a_e);
    nb += int'(b_e);
    nc += int'(c_e);
    if (cyc == 20000) begin
      fails++;
      end_sim();
    end
  end

  task automatic check(input string name, input logic [7:0] seen,
                       input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [3:0] d);
    @(negedge clk);
    mem = '{wr: 1'b1, addr: a, wdata: d};
    @(negedge clk);
    mem.wr = 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [3:0] exp);
    @(negedge clk);
    mem.addr = a;
    @(negedge clk);
    check("mem_rdata", 8'(rdata), 8'(exp));
  endtask

  task automatic instr(input logic on);
    @(negedge clk);
    en_instr = on;
    dis_instr = !on;
    @(negedge clk);
    en_instr = 1'b0;
    dis_instr = 1'b0;
  endtask

  // Lets any edge caused by a mode write drain before counting starts
  task automatic pulse(input int i, input int w);
    repeat (4) @(negedge clk);
    na = 0;
    nb = 0;
    nc = 0;
    pin[i] = 1'b1;
    repeat (w) @(negedge clk);
    mid = na + nb + nc;
    pin[i] = 1'b0;
    repeat (300) @(negedge clk);
  endtask

  task automatic end_sim();
    if (fails == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    rst_n = 1'b0;
    {en_instr, dis_instr, standby} = 3'h0;
    pin = 3'h0;
    req = 6'h00;
    en = 6'h00;
    mem = '{wr: 1'b0, addr: 12'h000, wdata: 4'h0};
    ex = '{8'h01, 8'h01, 8'h02, 8'h00};
    repeat (10) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    check("master_irq_enable", 8'(men), 8'h00);
    rd(eip_pkg::ADDR_PRIO_SEL, 4'h0);
    rd(eip_pkg::ADDR_EXT0_MODE, 4'h0);
    rd(eip_pkg::ADDR_EXT1_MODE, 4'h0);
    rd(12'hfb3, 4'h0);
    instr(1'b0);
    wr(eip_pkg::ADDR_PRIO_SEL, 4'hb);
    @(negedge clk);
    check("master_irq_enable", 8'(men), 8'h01);
    check("prio_code", 8'(pc), 8'h03);
    rd(eip_pkg::ADDR_PRIO_SEL, 4'hb);
    req = 6'h04;
    en = 6'h04;
    repeat (2) @(negedge clk);
    check("vec_irq", 8'(virq), 8'h04);
    check("high_prio_irq", 8'(hp), 8'h01);
    instr(1'b0);
    @(negedge clk);
    check("vec_irq", 8'(virq), 8'h00);
    check("standby_release", 8'(sbr), 8'h01);
    check("high_prio_irq", 8'(hp), 8'h00);
    instr(1'b1);
    @(negedge clk);
    check("master_irq_enable", 8'(men), 8'h01);
    pulse(2, 8);
    check("c edges", 8'(nc), 8'h02);
    pulse(1, 8);
    check("b edges", 8'(nb), 8'h01);
    wr(eip_pkg::ADDR_EXT1_MODE, 4'h1);
    pulse(1, 8);
    check("b early", 8'(mid), 8'h00);
    check("b edges", 8'(nb), 8'h01);
    for (int k = 0; k < 4; k++) begin
      wr(eip_pkg::ADDR_EXT0_MODE, 4'h4 | 4'(k));
      pulse(0, 8);
      check("a edges", 8'(na), ex[k]);
    end
    wr(eip_pkg::ADDR_EXT0_MODE, 4'h0);
    pulse(0, 2);
    check("a short", 8'(na), 8'h00);
    pulse(0, 16);
    check("a long", 8'(na), 8'h01);
    pin[0] = 1'b1;
    repeat (40) @(negedge clk);
    check("port_a_level", 8'(port_a), 8'h01);
    pin[0] = 1'b0;
    // Let the filter settle low so standby freezes a known level
    repeat (40) @(negedge clk);
    check("port_a_level", 8'(port_a), 8'h00);
    // Filter frozen in standby, so only the bypass path may wake
    standby = 1'b1;
    pulse(0, 16);
    check("a standby", 8'(na), 8'h00);
    wr(eip_pkg::ADDR_EXT0_MODE, 4'h4);
    pulse(0, 8);
    check("a bypass", 8'(na), 8'h01);
    standby = 1'b0;
    wr(eip_pkg::ADDR_EXT0_MODE, 4'h8);
    pulse(0, 40);
    check("a slow short", 8'(na), 8'h00);
    pulse(0, 200);
    check("a slow long", 8'(na), 8'h01);
    end_sim();
  end
endmodule
